/* rtl/adc_post_pkg.sv */
// constants, register map and field layout for the adc post-processing block
// Overview of operation
// [RL1] overrange flag follows input overrange by exactly 36 sample clocks
// [RL2] detect flag sets when magnitude exceeds 16-bit upper threshold at 0x47/0x48
// [RL3] upper threshold comparison reaches detect flag after seven sample clocks
// [RL4] threshold full scale is magnitude 2^13; dBFS is 20log(threshold/2^13)
// [RL5] detect flag holds until magnitude stays below lower threshold for dwell time
// [RL6] lower threshold at 0x49/0x4A compared at full resolution after pipeline delay
// [RL7] dwell time 1 to 65535 sample clocks from 0x4B/0x4C
// [RL8] dc correction is high-pass, bandwidth 2^(-k-14)*fs/2pi, k from 0x40 bits 5:2
// [RL9] software programs k only from 0 to 13
// [RL10] current 16-bit correction value readable at 0x41/0x42
// [RL11] freeze bit 6 stops estimate updates and keeps applying last value
// [RL12] clearing freeze resumes estimation and applies current value
// [RL13] correction subtracted from samples only while bit 1 of 0x40 set
// [RL14] detection uses magnitude only, sign ignored
// [RL15] detection active only while bit 0 of 0x45 set
// [RL16] shadowed writes apply together when 0x01 written to 0xFF; bit self-clears
// [RL17] dwell count restarts when magnitude returns to or above lower threshold
// [RL18] lower address of each pair holds low byte, higher address high byte
package adc_post_pkg;
    localparam int SAMPLE_W = 14;
    localparam int WORD_W = 16;
    localparam int MHZ_CLK = 125;
    // register offsets
    localparam logic [7:0] ADDR_DC_CTRL = 8'h40;
    localparam logic [7:0] ADDR_DC_VAL_LO = 8'h41;
    localparam logic [7:0] ADDR_DC_VAL_HI = 8'h42;
    localparam logic [7:0] ADDR_DET_ENABLE = 8'h45;
    localparam logic [7:0] ADDR_UPPER_LO = 8'h47;
    localparam logic [7:0] ADDR_UPPER_HI = 8'h48;
    localparam logic [7:0] ADDR_LOWER_LO = 8'h49;
    localparam logic [7:0] ADDR_LOWER_HI = 8'h4A;
    localparam logic [7:0] ADDR_DWELL_LO = 8'h4B;
    localparam logic [7:0] ADDR_DWELL_HI = 8'h4C;
    localparam logic [7:0] ADDR_UPDATE = 8'hFF;
    localparam logic [7:0] UPDATE_CMD = 8'h01;
    // fields of the correction control and detection enable registers
    localparam int BIT_DC_ENABLE = 1;
    localparam int BIT_DC_FREEZE = 6;
    localparam int K_LSB = 2;
    localparam int K_W = 4;
    localparam int BIT_DET_ENABLE = 0;
    localparam logic [3:0] K_MAX = 4'hD;
    localparam int K_OFFSET = 14;
    // fractional bits of the estimate: enough for the largest shift
    localparam int FRAC_W = 27;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DWELL = 16'h0001;
    // latencies in sample clocks
    localparam int OVERRANGE_LAT = 36;
    localparam int DETECT_LAT = 7;
endpackage : adc_post_pkg

/* rtl/offset_nulling_filter.sv */
// first-order high-pass dc estimator with freeze and enable
`timescale 1ns/1ps
`default_nettype none
module offset_nulling_filter (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic signed [13:0] sample,
    input wire logic [3:0] k_code,
    input wire logic freeze,
    input wire logic enable,
    output logic signed [13:0] corrected,
    output logic [15:0] dc_value
);
    localparam int EST_W = adc_post_pkg::SAMPLE_W + adc_post_pkg::FRAC_W + 1;
    logic signed [EST_W-1:0] estimate;
    logic signed [EST_W:0] diff;
    logic signed [EST_W:0] step;
    logic [4:0] shift;
    logic signed [15:0] live_dc;
    logic signed [15:0] held_dc;
    logic signed [15:0] applied;
    logic signed [16:0] difference;

    // out-of-range codes are clamped so the shifter never exceeds the fraction
    assign shift = 5'(((k_code > adc_post_pkg::K_MAX) ? adc_post_pkg::K_MAX : k_code) + adc_post_pkg::K_OFFSET); // [RL8] [RL9]
    assign diff = (EST_W+1)'(signed'({sample, {adc_post_pkg::FRAC_W{1'b0}}})) - (EST_W+1)'(estimate);
    assign step = diff >>> shift;
    assign live_dc = 16'(estimate >>> adc_post_pkg::FRAC_W);
    // while frozen the last value goes on being applied
    assign applied = freeze ? held_dc : live_dc; // [RL11] [RL12]
    assign difference = 17'(sample) - 17'(applied);

    // leaky integrator; holds still while frozen
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            estimate <= '0;
        end else if (!freeze) begin
            estimate <= estimate + EST_W'(step); // [RL8] [RL12]
        end
    end

    // capture the value to keep applying across a freeze
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            held_dc <= '0;
        end else if (!freeze) begin
            held_dc <= live_dc; // [RL11]
        end
    end

    // output path, saturated back to converter width
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            corrected <= '0;
            dc_value <= '0;
        end else begin
            dc_value <= applied; // [RL10]
            if (!enable) begin
                corrected <= sample; // [RL13]
            end else if (difference > 17'sh01FFF) begin
                corrected <= 14'h1FFF;
            end else if (difference < -17'sh02000) begin
                corrected <= 14'h2000;
            end else begin
                corrected <= difference[13:0]; // [RL13]
            end
        end
    end
endmodule : offset_nulling_filter
`default_nettype wire

/* rtl/threshold_detector.sv */
// magnitude threshold detector with dwell-time release
`timescale 1ns/1ps
`default_nettype none
module threshold_detector (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic signed [13:0] sample,
    input wire logic enable,
    input wire logic [15:0] upper,
    input wire logic [15:0] lower,
    input wire logic [15:0] dwell,
    output logic threshold_detect_flag
);
    logic [15:0] mag_pipe [0:adc_post_pkg::DETECT_LAT-2];
    logic [15:0] mag_now;
    logic [15:0] mag;
    logic [15:0] dwell_count;
    logic [15:0] dwell_target;

    // sign dropped; 2^13 is full scale so 16 bits hold any magnitude
    assign mag_now = sample[13] ? 16'(-17'(sample)) : 16'(sample); // [RL14] [RL4]
    assign mag = mag_pipe[adc_post_pkg::DETECT_LAT-2];
    // a zero dwell is below the 1 to 65535 range, so it behaves as one
    assign dwell_target = (dwell == 16'h0000) ? 16'h0001 : dwell; // [RL7]

    // delay line: six stages plus the flag register give seven cycles
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < adc_post_pkg::DETECT_LAT-1; i++) begin
                mag_pipe[i] <= '0;
            end
        end else begin
            mag_pipe[0] <= mag_now;
            for (int i = 1; i < adc_post_pkg::DETECT_LAT-1; i++) begin
                mag_pipe[i] <= mag_pipe[i-1]; // [RL3]
            end
        end
    end

    // set on upper crossing, clear after dwell cycles below lower
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            threshold_detect_flag <= 1'b0;
            dwell_count <= '0;
        end else if (!enable) begin
            threshold_detect_flag <= 1'b0; // [RL15]
            dwell_count <= '0;
        end else if (mag > upper) begin
            threshold_detect_flag <= 1'b1; // [RL2] [RL3]
            dwell_count <= '0;
        end else if (mag >= lower) begin
            dwell_count <= '0; // [RL17]
        end else if (threshold_detect_flag) begin
            if (dwell_count + 16'h0001 >= dwell_target) begin
                threshold_detect_flag <= 1'b0; // [RL5] [RL6]
                dwell_count <= '0;
            end else begin
                dwell_count <= dwell_count + 16'h0001; // [RL7]
            end
        end
    end
endmodule : threshold_detector
`default_nettype wire

/* rtl/adc_post_top.sv */
// top of the adc post-processing block: registers, overrange delay, filters
`timescale 1ns/1ps
`default_nettype none
module adc_post_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [13:0] adc_sample,
    input wire logic adc_overrange,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [13:0] sample_out,
    output logic overrange_flag,
    output logic threshold_detect_flag
);
    // shadow copies, written by software
    logic [7:0] sh_dc_ctrl;
    logic [7:0] sh_det_enable;
    logic [15:0] sh_upper;
    logic [15:0] sh_lower;
    logic [15:0] sh_dwell;
    // active copies, loaded by the transfer command
    logic [7:0] dc_ctrl;
    logic [7:0] det_enable;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] dwell;
    logic transfer_pending;
    logic [adc_post_pkg::OVERRANGE_LAT-1:0] or_pipe;
    logic [15:0] dc_value;
    logic [7:0] dc_hi_snap;
    logic [13:0] corrected;

    // merge a byte into the low or high half of a pair
    function automatic logic [15:0] put_byte(input logic [15:0] word, input logic hi, input logic [7:0] b);
        put_byte = hi ? {b, word[7:0]} : {word[15:8], b}; // [RL18]
    endfunction : put_byte

    // shadow register writes
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_dc_ctrl <= adc_post_pkg::RST_BYTE;
            sh_det_enable <= adc_post_pkg::RST_BYTE;
            sh_upper <= '0;
            sh_lower <= '0;
            sh_dwell <= adc_post_pkg::RST_DWELL;
        end else if (reg_wr) begin
            case (reg_addr)
                adc_post_pkg::ADDR_DC_CTRL: sh_dc_ctrl <= reg_wdata;
                adc_post_pkg::ADDR_DET_ENABLE: sh_det_enable <= reg_wdata;
                adc_post_pkg::ADDR_UPPER_LO: sh_upper <= put_byte(sh_upper, 1'b0, reg_wdata);
                adc_post_pkg::ADDR_UPPER_HI: sh_upper <= put_byte(sh_upper, 1'b1, reg_wdata);
                adc_post_pkg::ADDR_LOWER_LO: sh_lower <= put_byte(sh_lower, 1'b0, reg_wdata);
                adc_post_pkg::ADDR_LOWER_HI: sh_lower <= put_byte(sh_lower, 1'b1, reg_wdata);
                adc_post_pkg::ADDR_DWELL_LO: sh_dwell <= put_byte(sh_dwell, 1'b0, reg_wdata);
                adc_post_pkg::ADDR_DWELL_HI: sh_dwell <= put_byte(sh_dwell, 1'b1, reg_wdata);
                default: ;
            endcase
        end
    end

    // transfer bit: set by the command, cleared by the copy one cycle later
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            transfer_pending <= 1'b0;
        end else if (reg_wr && reg_addr == adc_post_pkg::ADDR_UPDATE && reg_wdata == adc_post_pkg::UPDATE_CMD) begin
            transfer_pending <= 1'b1; // [RL16]
        end else begin
            transfer_pending <= 1'b0; // [RL16]
        end
    end

    // all active copies load on the same edge so the block never sees a mix
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dc_ctrl <= adc_post_pkg::RST_BYTE;
            det_enable <= adc_post_pkg::RST_BYTE;
            upper <= '0;
            lower <= '0;
            dwell <= adc_post_pkg::RST_DWELL;
        end else if (transfer_pending) begin
            dc_ctrl <= sh_dc_ctrl; // [RL16]
            det_enable <= sh_det_enable;
            upper <= sh_upper;
            lower <= sh_lower;
            dwell <= sh_dwell;
        end
    end

    // overrange seen at the pipeline output, delayed to match
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            or_pipe <= '0;
        end else begin
            or_pipe <= {or_pipe[adc_post_pkg::OVERRANGE_LAT-2:0], adc_overrange}; // [RL1]
        end
    end
    assign overrange_flag = or_pipe[adc_post_pkg::OVERRANGE_LAT-1]; // [RL1]

    offset_nulling_filter u_dc (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .sample(signed'(adc_sample)),
        .k_code(dc_ctrl[adc_post_pkg::K_LSB +: adc_post_pkg::K_W]), // [RL8]
        .freeze(dc_ctrl[adc_post_pkg::BIT_DC_FREEZE]), // [RL11]
        .enable(dc_ctrl[adc_post_pkg::BIT_DC_ENABLE]), // [RL13]
        .corrected(corrected),
        .dc_value(dc_value)
    );
    assign sample_out = corrected;

    // detection looks at the raw samples, ahead of the correction
    threshold_detector u_det (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .sample(signed'(adc_sample)),
        .enable(det_enable[adc_post_pkg::BIT_DET_ENABLE]), // [RL15]
        .upper(upper),
        .lower(lower),
        .dwell(dwell),
        .threshold_detect_flag(threshold_detect_flag)
    );

    // reading the low byte freezes the high byte so the pair stays coherent
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dc_hi_snap <= '0;
        end else if (reg_rd && reg_addr == adc_post_pkg::ADDR_DC_VAL_LO) begin
            dc_hi_snap <= dc_value[15:8]; // [RL18]
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                adc_post_pkg::ADDR_DC_CTRL: reg_rdata <= sh_dc_ctrl;
                adc_post_pkg::ADDR_DC_VAL_LO: reg_rdata <= dc_value[7:0]; // [RL10]
                adc_post_pkg::ADDR_DC_VAL_HI: reg_rdata <= dc_hi_snap; // [RL10]
                adc_post_pkg::ADDR_DET_ENABLE: reg_rdata <= sh_det_enable;
                adc_post_pkg::ADDR_UPPER_LO: reg_rdata <= sh_upper[7:0];
                adc_post_pkg::ADDR_UPPER_HI: reg_rdata <= sh_upper[15:8];
                adc_post_pkg::ADDR_LOWER_LO: reg_rdata <= sh_lower[7:0];
                adc_post_pkg::ADDR_LOWER_HI: reg_rdata <= sh_lower[15:8];
                adc_post_pkg::ADDR_DWELL_LO: reg_rdata <= sh_dwell[7:0];
                adc_post_pkg::ADDR_DWELL_HI: reg_rdata <= sh_dwell[15:8];
                adc_post_pkg::ADDR_UPDATE: reg_rdata <= {7'h00, transfer_pending};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : adc_post_top
`default_nettype wire

/* test/adc_post_monitor.sv */
// port-level checker for the adc post-processing block
`timescale 1ns/1ps
`default_nettype none
module adc_post_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [13:0] adc_sample,
    input wire logic adc_overrange,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [13:0] sample_out,
    input wire logic overrange_flag,
    input wire logic threshold_detect_flag
);
    logic [5:0] age;
    logic [15:0] sh_up, up;
    logic sh_en, en, sh_dc, dc, xfer;
    logic [13:0] mag;
    // sign is dropped; the most negative code still maps to its true size
    assign mag = adc_sample[13] ? 14'(-adc_sample) : adc_sample;
    // edges since reset, so delayed history is only trusted once it is real
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            age <= 6'h00;
        end else if (age != 6'h3F) begin
            age <= age + 6'h01;
        end
    end
    // mirror of shadow writes; active copies load the edge after a transfer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {sh_up, up, sh_en, en, sh_dc, dc, xfer} <= '0;
        end else begin
            if (reg_wr && reg_addr == 8'h47) sh_up[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == 8'h48) sh_up[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == 8'h45) sh_en <= reg_wdata[0];
            if (reg_wr && reg_addr == 8'h40) sh_dc <= reg_wdata[1];
            xfer <= reg_wr && reg_addr == 8'hFF && reg_wdata == 8'h01;
            if (xfer) {up, en, dc} <= {sh_up, sh_en, sh_dc};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_overrange_delay: assert property (age > 6'h24 |-> overrange_flag == $past(adc_overrange, 36))
        else $error("overrange flag is not the input 36 edges late");
    a_detect_cause: assert property ($rose(threshold_detect_flag) |-> $past(en, 7) && $past(mag, 7) > $past(up, 7))
        else $error("detect flag rose without an excess seven edges earlier");
    a_detect_off: assert property (!en [*8] |-> !threshold_detect_flag)
        else $error("detect flag set while detection disabled");
    a_pass_through: assert property (!dc ##1 !dc |-> sample_out == $past(adc_sample))
        else $error("uncorrected path altered the sample");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_shadow_readback: assert property (reg_wr && reg_addr == 8'h47 ##1 reg_rd && reg_addr == 8'h47 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("threshold low byte not read back");
    a_xfer_set: assert property (reg_wr && reg_addr == 8'hFF && reg_wdata == 8'h01 ##1 reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h01)
        else $error("transfer bit not seen set");
    a_xfer_clear: assert property (reg_wr && reg_addr == 8'hFF && reg_wdata == 8'h01 ##2 reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h00)
        else $error("transfer bit did not clear itself");
endmodule : adc_post_monitor
bind adc_post_top adc_post_monitor u_monitor (.mclk(mclk), .sys_rst(sys_rst), .adc_sample(adc_sample),
    .adc_overrange(adc_overrange), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_out(sample_out), .overrange_flag(overrange_flag),
    .threshold_detect_flag(threshold_detect_flag));
`default_nettype wire

/* test/adc_stream_model.sv */
// behavioural converter pipeline output feeding the block one sample a clock
`timescale 1ns/1ps
`default_nettype none
module adc_stream_model (
    input wire logic mclk,
    input wire logic [13:0] level,
    input wire logic ovr_req,
    output logic [13:0] adc_sample,
    output logic adc_overrange
);
    // defined from time zero so the block never sees an unknown sample
    initial begin
        adc_sample = 14'h0000;
        adc_overrange = 1'b0;
    end
    // registered stage: launches just after the edge, costing one clock
    always @(posedge mclk) begin
        adc_sample <= #1 level;
        adc_overrange <= #1 ovr_req;
    end
endmodule : adc_stream_model
`default_nettype wire

/* test/overrange_fast_detect_dc_correction_bench.sv */
// self-checking bench for the adc post-processing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module overrange_fast_detect_dc_correction_bench;
    logic mclk, sys_rst, reg_wr, reg_rd, ovr_req, adc_overrange, overrange_flag, threshold_detect_flag;
    logic [13:0] level, adc_sample, sample_out, s1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [15:0] d1, d2;
    int n_errors, tests_run, cyc;
    adc_stream_model src (.mclk(mclk), .level(level), .ovr_req(ovr_req), .adc_sample(adc_sample),
        .adc_overrange(adc_overrange));
    adc_post_top dut (.mclk(mclk), .sys_rst(sys_rst), .adc_sample(adc_sample), .adc_overrange(adc_overrange),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_out(sample_out), .overrange_flag(overrange_flag), .threshold_detect_flag(threshold_detect_flag));
    // strobes stay up until the next call or idle, so back-to-back cycles work
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1;
        q = reg_rdata;
    endtask : rd
    task automatic idle(input int n);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask : idle
    // low byte first, since that read snapshots the high byte
    task automatic rd_dc(output logic [15:0] q);
        logic [7:0] b;
        rd(8'h41, b);
        q[7:0] = b;
        rd(8'h42, b);
        q[15:8] = b;
    endtask : rd_dc
    task automatic test_done();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // hang guard: the sequence needs under 30000 clocks
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, ovr_req, level, reg_addr, reg_wdata} = {1'b1, 33'h0};
        {n_errors, tests_run, cyc} = '0;
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        rd(8'h4B, v); `CHK("dwell_low", 8'h01, v)
        rd(8'h40, v); `CHK("dc_control", 8'h00, v)
        // upper 0x0FFF, lower 0x0A1D, dwell 4, detection on, all still shadowed
        wr(8'h47, 8'hFF); rd(8'h47, v); `CHK("upper_low", 8'hFF, v)
        wr(8'h48, 8'h0F); wr(8'h49, 8'h1D); wr(8'h4A, 8'h0A); wr(8'h4B, 8'h04); wr(8'h4C, 8'h00);
        wr(8'h45, 8'h01);
        level = 14'h1FFF;
        idle(12); `CHK("flag_shadowed", 1'b0, threshold_detect_flag)
        level = 14'h0000;
        idle(12);
        wr(8'hFF, 8'h01); rd(8'hFF, v); `CHK("xfer_set", 8'h01, v)
        rd(8'hFF, v); `CHK("xfer_clear", 8'h00, v)
        level = 14'h0FFF;
        idle(12); `CHK("flag_at_upper", 1'b0, threshold_detect_flag)
        // one-sample excursions of either sign trip the flag after seven clocks
        // the flag must hold through three quiet samples and drop on the fourth, the dwell of 4
        for (int i = 0; i < 2; i++) begin
            level = (i != 0) ? 14'h2001 : 14'h1FFF;
            idle(1);
            level = 14'h0000;
            idle(6); `CHK("flag_early", 1'b0, threshold_detect_flag)
            idle(1); `CHK("flag_set", 1'b1, threshold_detect_flag)
            idle(3); `CHK("flag_dwell_hold", 1'b1, threshold_detect_flag)
            idle(1); `CHK("flag_release", 1'b0, threshold_detect_flag)
            idle(16);
        end
        // a sample at the lower threshold every fourth clock keeps the dwell from completing
        level = 14'h1FFF;
        idle(1);
        repeat (10) begin
            level = 14'h0000;
            idle(3);
            level = 14'h0A1D;
            idle(1);
        end
        `CHK("flag_dwell_restart", 1'b1, threshold_detect_flag)
        level = 14'h0000;
        idle(20); `CHK("flag_dwell_done", 1'b0, threshold_detect_flag)
        wr(8'h45, 8'h00); wr(8'hFF, 8'h01);
        level = 14'h1FFF;
        idle(12); `CHK("flag_disabled", 1'b0, threshold_detect_flag)
        level = 14'h0000;
        ovr_req = 1'b1;
        idle(1);
        ovr_req = 1'b0;
        idle(35); `CHK("ovr_early", 1'b0, overrange_flag)
        idle(1); `CHK("ovr_on", 1'b1, overrange_flag)
        idle(1); `CHK("ovr_off", 1'b0, overrange_flag)
        // correction on with k=0, the widest legal bandwidth, on a constant offset
        level = 14'h0100;
        wr(8'h40, 8'h02); wr(8'hFF, 8'h01);
        rd(8'h40, v); `CHK("dc_control", 8'h02, v)
        idle(20000); `CHK("dc_applied", 1'b1, sample_out < 14'h0100)
        wr(8'h40, 8'h42); wr(8'hFF, 8'h01);
        idle(4);
        rd_dc(d1); `CHK("dc_value_set", 1'b1, d1 != 16'h0000)
        s1 = sample_out;
        idle(2000);
        rd_dc(d2); `CHK("dc_frozen", d1, d2)
        `CHK("out_frozen", s1, sample_out)
        wr(8'h40, 8'h02); wr(8'hFF, 8'h01);
        idle(2000);
        rd_dc(d2); `CHK("dc_resumed", 1'b1, d1 != d2)
        wr(8'h40, 8'h00); wr(8'hFF, 8'h01);
        idle(4); `CHK("dc_bypass", 14'h0100, sample_out)
        test_done();
    end
endmodule : overrange_fast_detect_dc_correction_bench
`default_nettype wire
